// ==== hw/aux_diag_consts.vh ====
/*
  Constants for the auxiliary port diagnostic formatter: register map,
  field positions, reset values, modes, characters and timing.
  Assumes inclusion by bare name from the design file.
*/
// Behaviour
// - Counters kept; reading paused while accessed (here reading goes on during a counter access)
// - Diagnosis mode sends all codes, rejected too
// - Host result carries no diagnosis by default
// - Monitor copies host traffic, drops protocol bytes
// - Monitored lines prefixed O or I
// - Lost monitor data shown as dots
// - Manual aux input forwarded to host
// - Power-up self-test first, no results meanwhile
// - Self-test checks hardware, scanners, sends code
// - Code 15000 means passed, others error
// - Test on demand; reading resumes on command
// - Standard statistics per pulse passed on
// - Extended adds per-scanner detail records
// - Summarized mode passes single-line records
// - Accumulated modes report every 100th pulse
// - I/O change emits stamped status line
// - Line has 19 positions, dot or one
// - Serial trigger still needs encoder pulses
// - No encoder pulses, no field end
`ifndef AUX_DIAG_CONSTS_VH
`define AUX_DIAG_CONSTS_VH
`define A_MODE     8'h00
`define A_CTRL     8'h04
`define A_FIELD    8'h08
`define A_STATUS   8'h0c
`define A_PULSES   8'h10
`define A_CODES    8'h14
`define A_SCANEXP  8'h18
`define C_TEST     0
`define C_HOLD     1
`define C_SWTRIG   2
`define C_RESUME   3
`define C_HDIAG    4
`define M_DIAG     4'h0
`define M_MON      4'h1
`define M_MAN      4'h2
`define M_STD      4'h3
`define M_EXT      4'h4
`define M_SUM      4'h5
`define M_ACCSTD   4'h6
`define M_ACCSUM   4'h7
`define M_IOMON    4'h8
`define M_LAST     4'h8
`define FIELD_RST  16'h000a
`define SCAN_RST   4'h1
`define PASS_CODE  16'h3a98
`define ACC_PULSES 7'h64
`define IO_BITS    19
`define CH_O       8'h4f
`define CH_I       8'h49
`define CH_DOT     8'h2e
`define CH_ONE     8'h31
`define CH_ZERO    8'h30
`define CH_SP      8'h20
`define CH_CR      8'h0d
`define CH_LF      8'h0a
`define DOTS       3'h6
`define IO_LEN     5'h1f
`define TST_LEN    5'h07
`define MS_NS      1000000
`define CLK_NS     10
`define MS_CYC     (`MS_NS / `CLK_NS)
`endif

// ==== hw/aux_diag_port.v ====
/*
  Auxiliary port diagnostic formatter with APB register slave,
  self-test sequencer, reading field control and output modes.
  Assumes byte strobes from the host, code and statistics logic on
  ref_clk, and a UART on the auxiliary port with valid/ready.
*/
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps
`include "aux_diag_consts.vh"
module aux_diag_port #(
  parameter MS_CYC   = `MS_CYC,
  parameter TEST_CYC = 1000,
  parameter FDEPTH   = 16,
  parameter FAW      = 4
) (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        trigPin,
  input  wire        encPin,
  input  wire [18:0] ioPins,
  input  wire        hwFault,
  input  wire [3:0]  scanCount,
  input  wire        scanErr,
  input  wire        codeValid,
  input  wire [7:0]  codeData,
  input  wire        codeEnd,
  input  wire        statValid,
  input  wire [7:0]  statData,
  input  wire [1:0]  statKind,
  input  wire        statEnd,
  input  wire        errValid,
  input  wire [7:0]  errData,
  input  wire        hostTxValid,
  input  wire        hostRxValid,
  input  wire [7:0]  hostByte,
  input  wire        hostCtl,
  input  wire        hostEnd,
  input  wire        auxInValid,
  input  wire [7:0]  auxInData,
  output reg         auxValid,
  output reg  [7:0]  auxData,
  input  wire        auxReady,
  output reg         hostOutValid,
  output reg  [7:0]  hostOutData,
  output reg         hostOutEnd,
  output reg         readEnable,
  output reg         resultGo,
  output reg         paramLoad,
  output reg         hostDiag
);
  localparam TST = 2'd0, RD = 2'd1, HLD = 2'd2, OPD = 2'd3;

  function [7:0] hexCh;
    input [3:0] v;
    hexCh = (v < 4'ha) ? {4'h3, v} : (8'h37 + {4'h0, v});
  endfunction

  reg [1:0]  st_q;
  reg        boot_q;
  reg [3:0]  mode_q;
  reg [4:0]  ctrl_q;
  reg [15:0] field_q, encLeft_q, pulses_q, codes_q, tms_q, incs_q;
  reg [3:0]  scanExp_q;
  reg [1:0]  tErr_q;
  reg [31:0] tcnt_q, ms_q;
  reg [1:0]  trS_q, enS_q;
  reg        enD_q, trD_q, inFld_q, fldRun_q;
  reg [18:0] io1_q, io2_q, ioD_q;
  reg [6:0]  accCnt_q;
  reg        accOk_q, lineOn_q, lost_q;
  reg [2:0]  dots_q;
  reg [4:0]  seqIdx_q;
  reg        seqIo_q;
  reg [18:0] ioSnap_q;
  reg [15:0] tSnap_q, nSnap_q;
  reg [7:0]  p0_q, p1_q;
  reg [1:0]  pn_q;
  reg [7:0]  fmem [0:FDEPTH-1];
  reg [FAW:0] wp_q, rp_q;

  wire wrEn = psel & penable & pwrite;
  wire encRise = enS_q[1] & ~enD_q;
  wire trig = ctrl_q[`C_SWTRIG] ? ctrl_q[`C_SWTRIG] : trS_q[1];
  wire reading = (st_q == RD);
  wire full = (wp_q[FAW] != rp_q[FAW]) && (wp_q[FAW-1:0] == rp_q[FAW-1:0]);
  wire empty = (wp_q == rp_q);
  wire msTick = (ms_q == MS_CYC - 1);

  // Input synchronisers and edge history
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      trS_q <= 2'b00;
      enS_q <= 2'b00;
      enD_q <= 1'b0;
      io1_q <= 19'h0;
      io2_q <= 19'h0;
      ioD_q <= 19'h0;
    end else begin
      trS_q <= {trS_q[0], trigPin};
      enS_q <= {enS_q[0], encPin};
      enD_q <= enS_q[1];
      io1_q <= ioPins;
      io2_q <= io1_q;
      ioD_q <= io2_q;
    end
  end

  // APB register writes, state machine and counters
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= `M_DIAG;
      ctrl_q <= 5'h0;
      field_q <= `FIELD_RST;
      scanExp_q <= `SCAN_RST;
      st_q <= TST;
      boot_q <= 1'b1;
      tcnt_q <= 32'h0;
      tErr_q <= 2'd0;
      pulses_q <= 16'h0;
      codes_q <= 16'h0;
      paramLoad <= 1'b0;
    end else begin
      paramLoad <= 1'b0;
      ctrl_q[`C_TEST] <= 1'b0;
      ctrl_q[`C_RESUME] <= 1'b0;
      if (wrEn) begin
        if (paddr == `A_MODE) begin
          if (pwdata[3:0] <= `M_LAST)
            mode_q <= pwdata[3:0];
        end else if (paddr == `A_CTRL) begin
          ctrl_q <= pwdata[4:0];
        end else if (paddr == `A_FIELD) begin
          field_q <= pwdata[15:0];
        end else if (paddr == `A_SCANEXP) begin
          scanExp_q <= pwdata[3:0];
        end
      end
      // Counting wins over a same-cycle clear
      if (wrEn && paddr == `A_PULSES)
        pulses_q <= 16'h0;
      if (resultGo)
        pulses_q <= pulses_q + 16'h1;
      if (wrEn && paddr == `A_CODES)
        codes_q <= 16'h0;
      if (reading && codeValid && codeEnd)
        codes_q <= codes_q + 16'h1;
      case (st_q)
        TST: begin
          tcnt_q <= tcnt_q + 32'h1;
          if (tcnt_q == TEST_CYC - 1) begin
            tcnt_q <= 32'h0;
            tErr_q <= hwFault ? 2'd1 :
                      (scanCount != scanExp_q) ? 2'd2 :
                      scanErr ? 2'd3 : 2'd0;
            boot_q <= 1'b0;
            paramLoad <= boot_q;
            st_q <= boot_q ? RD : HLD;
          end
        end
        RD: begin
          if (ctrl_q[`C_TEST])
            st_q <= TST;
          else if (ctrl_q[`C_HOLD])
            st_q <= OPD;
        end
        HLD: begin
          if (ctrl_q[`C_RESUME])
            st_q <= RD;
          else if (ctrl_q[`C_TEST])
            st_q <= TST;
        end
        default: begin
          if (!ctrl_q[`C_HOLD])
            st_q <= RD;
        end
      endcase
    end
  end

  // APB read side, zero wait states
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel && !penable) begin
        if (paddr == `A_MODE)
          prdata <= {28'h0, mode_q};
        else if (paddr == `A_CTRL)
          prdata <= {27'h0, ctrl_q};
        else if (paddr == `A_FIELD)
          prdata <= {16'h0, field_q};
        else if (paddr == `A_STATUS)
          prdata <= {`PASS_CODE + {14'h0, tErr_q}, 13'h0,
                     lost_q, st_q};
        else if (paddr == `A_PULSES)
          prdata <= {16'h0, pulses_q};
        else if (paddr == `A_CODES)
          prdata <= {16'h0, codes_q};
        else if (paddr == `A_SCANEXP)
          prdata <= {28'h0, scanExp_q};
        else
          pslverr <= 1'b1;
      end
    end
  end

  // Reading field: ends only after encoder travel past trigger off
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      trD_q <= 1'b0;
      inFld_q <= 1'b0;
      fldRun_q <= 1'b0;
      encLeft_q <= 16'h0;
      resultGo <= 1'b0;
      readEnable <= 1'b0;
      hostDiag <= 1'b0;
      accCnt_q <= 7'h0;
      accOk_q <= 1'b0;
    end else begin
      readEnable <= reading;
      hostDiag <= ctrl_q[`C_HDIAG];
      resultGo <= 1'b0;
      trD_q <= trig;
      if (!reading) begin
        inFld_q <= 1'b0;
        fldRun_q <= 1'b0;
      end else if (trig && !trD_q) begin
        inFld_q <= 1'b1;
        fldRun_q <= 1'b0;
      end else if (inFld_q && !trig) begin
        inFld_q <= 1'b0;
        fldRun_q <= 1'b1;
        encLeft_q <= field_q;
      end else if (fldRun_q && encRise) begin
        encLeft_q <= encLeft_q - 16'h1;
        if (encLeft_q <= 16'h1) begin
          fldRun_q <= 1'b0;
          resultGo <= 1'b1;
        end
      end
      if (resultGo) begin
        if (accCnt_q == `ACC_PULSES - 7'h1) begin
          accCnt_q <= 7'h0;
          accOk_q <= 1'b1;
        end else begin
          accCnt_q <= accCnt_q + 7'h1;
        end
      end else if (statValid && statEnd) begin
        accOk_q <= 1'b0;
      end
    end
  end

  // Source selection: up to two bytes per event, by mode
  reg       ev;
  reg [1:0] evN;
  reg [7:0] e0, e1;
  reg       statPass;
  always @* begin
    ev = 1'b0;
    evN = 2'd1;
    e0 = 8'h0;
    e1 = 8'h0;
    statPass = 1'b0;
    case (mode_q)
      `M_STD:    statPass = (statKind == 2'd0);
      `M_EXT:    statPass = (statKind != 2'd2);
      `M_SUM:    statPass = (statKind == 2'd2);
      `M_ACCSTD: statPass = accOk_q && (statKind == 2'd0);
      `M_ACCSUM: statPass = accOk_q && (statKind == 2'd2);
      default:   statPass = 1'b0;
    endcase
    if (mode_q == `M_DIAG) begin
      if (reading && codeValid) begin
        ev = 1'b1;
        e0 = codeData;
        e1 = `CH_LF;
        evN = codeEnd ? 2'd2 : 2'd1;
      end
    end else if (mode_q == `M_MON) begin
      if ((hostTxValid || hostRxValid) && !hostCtl) begin
        ev = 1'b1;
        if (!lineOn_q) begin
          e0 = hostTxValid ? `CH_O : `CH_I;
          e1 = hostByte;
          evN = 2'd2;
        end else begin
          e0 = hostByte;
        end
      end else if ((hostTxValid || hostRxValid) && hostEnd) begin
        ev = 1'b1;
        e0 = `CH_CR;
        e1 = `CH_LF;
        evN = 2'd2;
      end
    end else if (statPass && statValid && reading) begin
      ev = 1'b1;
      e0 = statData;
    end else if (mode_q >= `M_STD && mode_q <= `M_ACCSUM && errValid) begin
      ev = 1'b1;
      e0 = errData;
    end
  end

  // Multi-byte messages: I/O status line and self-test code
  reg [7:0] sc;
  reg [4:0] k;
  always @* begin
    sc = `CH_SP;
    k = 5'h0;
    if (!seqIo_q) begin
      if (seqIdx_q == 5'd0)
        sc = `CH_ONE;
      else if (seqIdx_q == 5'd1)
        sc = 8'h35;
      else if (seqIdx_q == 5'd4)
        sc = `CH_ZERO + {6'h0, tErr_q};
      else if (seqIdx_q == 5'd5)
        sc = `CH_CR;
      else if (seqIdx_q == 5'd6)
        sc = `CH_LF;
      else
        sc = `CH_ZERO;
    end else if (seqIdx_q < 5'd4) begin
      sc = hexCh(tSnap_q[5'd15 - {seqIdx_q[1:0], 2'b00} -: 4]);
    end else if (seqIdx_q >= 5'd5 && seqIdx_q < 5'd9) begin
      k = seqIdx_q - 5'd5;
      sc = hexCh(nSnap_q[5'd15 - {k[1:0], 2'b00} -: 4]);
    end else if (seqIdx_q >= 5'd10 && seqIdx_q < 5'd29) begin
      k = seqIdx_q - 5'd10;
      sc = ioSnap_q[k] ? `CH_ONE : `CH_DOT;
    end else if (seqIdx_q == 5'd29) begin
      sc = `CH_CR;
    end else if (seqIdx_q == 5'd30) begin
      sc = `CH_LF;
    end
  end

  wire seqBusy = (seqIdx_q != 5'd0) || (st_q == TST && tcnt_q == TEST_CYC - 1);
  wire ioEv = (mode_q == `M_IOMON) && (io2_q != ioD_q);
  wire seqLd = !ev && pn_q == 2'd0;

  // Pending bytes, sequencers, drop and dot logic
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      p0_q <= 8'h0;
      p1_q <= 8'h0;
      pn_q <= 2'd0;
      lineOn_q <= 1'b0;
      lost_q <= 1'b0;
      dots_q <= 3'h0;
      seqIdx_q <= 5'h0;
      seqIo_q <= 1'b0;
      ioSnap_q <= 19'h0;
      tSnap_q <= 16'h0;
      nSnap_q <= 16'h0;
      tms_q <= 16'h0;
      incs_q <= 16'h0;
      ms_q <= 32'h0;
      wp_q <= {(FAW+1){1'b0}};
    end else begin
      ms_q <= msTick ? 32'h0 : ms_q + 32'h1;
      if (msTick)
        tms_q <= tms_q + 16'h1;
      if (encRise)
        incs_q <= incs_q + 16'h1;
      if (ev && mode_q == `M_MON)
        lineOn_q <= (evN == 2'd1) || (e0 != `CH_CR);
      if (pn_q != 2'd0 && !full) begin
        fmem[wp_q[FAW-1:0]] <= p0_q;
        wp_q <= wp_q + 1'b1;
        p0_q <= p1_q;
        pn_q <= pn_q - 2'd1;
      end
      if (ev) begin
        if (pn_q != 2'd0) begin
          lost_q <= 1'b1;
        end else begin
          p0_q <= e0;
          p1_q <= e1;
          pn_q <= evN;
        end
      end else if (seqIdx_q == 5'd0 && ioEv) begin
        seqIo_q <= 1'b1;
        seqIdx_q <= 5'd1;
        ioSnap_q <= io2_q;
        tSnap_q <= tms_q;
        nSnap_q <= incs_q;
        p0_q <= hexCh(tms_q[15:12]);
        pn_q <= 2'd1;
      end else if (seqIdx_q == 5'd0 && seqBusy) begin
        seqIo_q <= 1'b0;
        seqIdx_q <= 5'd1;
        p0_q <= `CH_ONE;
        pn_q <= 2'd1;
      end else if (seqIdx_q != 5'd0 && seqLd) begin
        p0_q <= sc;
        pn_q <= 2'd1;
        if (seqIdx_q == (seqIo_q ? `IO_LEN : `TST_LEN) - 5'd1)
          seqIdx_q <= 5'd0;
        else
          seqIdx_q <= seqIdx_q + 5'd1;
      end else if (lost_q && seqLd && mode_q == `M_MON) begin
        p0_q <= `CH_DOT;
        pn_q <= 2'd1;
        if (dots_q == `DOTS - 3'h1) begin
          dots_q <= 3'h0;
          lost_q <= 1'b0;
        end else begin
          dots_q <= dots_q + 3'h1;
        end
      end
      if (ioEv && seqIdx_q != 5'd0)
        lost_q <= 1'b1;
    end
  end

  // Output stage to the aux UART
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      auxValid <= 1'b0;
      auxData <= 8'h0;
      rp_q <= {(FAW+1){1'b0}};
    end else if (!auxValid || auxReady) begin
      auxValid <= !empty;
      auxData <= fmem[rp_q[FAW-1:0]];
      if (!empty)
        rp_q <= rp_q + 1'b1;
    end
  end

  // Manual entry: aux bytes forwarded to host, CR closes string
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hostOutValid <= 1'b0;
      hostOutData <= 8'h0;
      hostOutEnd <= 1'b0;
    end else begin
      hostOutValid <= reading && (mode_q == `M_MAN) && auxInValid;
      hostOutData <= auxInData;
      hostOutEnd <= reading && (mode_q == `M_MAN) && auxInValid &&
                    (auxInData == `CH_CR);
    end
  end
endmodule // aux_diag_port

// ==== testbench/aux_diag_port_sva.sv ====
/*
  Checker for the auxiliary diagnostic port: bus answers, stream holding,
  manual forwarding, start-up quiet period and pulse widths.
  Assumes it is bound onto aux_diag_port with TEST_CYC handed on.
*/
`timescale 1ns/10ps
module aux_diag_port_sva #(
  parameter TEST_CYC = 1000
) (
  input wire        ref_clk,
  input wire        resetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        auxValid,
  input wire [7:0]  auxData,
  input wire        auxReady,
  input wire        auxInValid,
  input wire [7:0]  auxInData,
  input wire        hostOutValid,
  input wire [7:0]  hostOutData,
  input wire        hostOutEnd,
  input wire        readEnable,
  input wire        resultGo,
  input wire        paramLoad,
  input wire        hostDiag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  reg [31:0] upCnt_q;
  reg        loaded_q;
  // Cycles since reset release and the one-shot parameter load
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      upCnt_q  <= 32'h0;
      loaded_q <= 1'b0;
    end else begin
      if (upCnt_q < TEST_CYC) upCnt_q <= upCnt_q + 32'h1;
      if (paramLoad) loaded_q <= 1'b1;
    end
  end
  sequence apbSetup; psel && !penable; endsequence
  sequence apbDone; psel && penable && pready; endsequence
  AST_APB_ANSWER: assert property (apbSetup |=> apbDone)
    else $error("no answer in access cycle");
  AST_APB_ERR: assert property (pslverr |-> apbDone)
    else $error("error flag outside access cycle");
  AST_AUX_HOLD: assert property (auxValid && !auxReady |=> auxValid && $stable(auxData))
    else $error("aux byte changed before acceptance");
  AST_MAN_FWD: assert property (hostOutValid |-> $past(auxInValid) && hostOutData == $past(auxInData))
    else $error("host byte not the entered byte");
  AST_MAN_END: assert property (hostOutEnd |-> hostOutValid && hostOutData == 8'h0d)
    else $error("string end without carriage return");
  AST_TEST_QUIET: assert property (upCnt_q < TEST_CYC |-> !readEnable && !resultGo)
    else $error("reading during power-up test");
  AST_PARAM_ONCE: assert property (paramLoad |-> !loaded_q ##1 !paramLoad)
    else $error("parameter load repeated");
  AST_RESULT_PULSE: assert property (resultGo |-> readEnable ##1 !resultGo)
    else $error("result outside reading");
  AST_DIAG_WRITE: assert property ($rose(hostDiag) |->
    $past(psel && penable && pwrite && paddr == 8'h04 && pwdata[4], 2))
    else $error("host diagnosis without write");
endmodule // aux_diag_port_sva
bind aux_diag_port aux_diag_port_sva #(.TEST_CYC(TEST_CYC)) chk (
  .ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .auxValid, .auxData, .auxReady, .auxInValid, .auxInData,
  .hostOutValid, .hostOutData, .hostOutEnd, .readEnable, .resultGo,
  .paramLoad, .hostDiag
);

// ==== testbench/aux_term_model.sv ====
/*
  Terminal on the auxiliary port: takes bytes with random stalls and
  keeps them in order. Assumes the bench seeds the generator.
*/
`timescale 1ns/10ps
module aux_term_model (
  input  wire       ref_clk,
  input  wire       resetn,
  input  wire       auxValid,
  input  wire [7:0] auxData,
  output reg        auxReady
);
  logic [7:0] rxq[$];
  initial auxReady = 1'b0;
  // Accept at each ready edge, then choose the next readiness
  always @(posedge ref_clk) begin
    if (resetn && auxValid === 1'b1 && auxReady) rxq.push_back(auxData);
    auxReady <= resetn && ($urandom % 4 != 0);
  end
endmodule // aux_term_model

// ==== testbench/aux_diag_port_tb_top.sv ====
/*
  Self-checking bench for the auxiliary diagnostic port: registers,
  self-test lines, output modes, manual entry and reading control.
  Assumes aux_diag_port, its constants header and the terminal model.
*/
`timescale 1ns/10ps
`include "aux_diag_consts.vh"
module aux_diag_port_tb_top;
  logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, codeData, statData, errData, hostByte, auxInData;
  logic [7:0]  auxData, hostOutData, x;
  logic [31:0] pwdata, prdata, rd;
  logic        trigPin, encPin, hwFault, scanErr, codeValid, codeEnd;
  logic        statValid, statEnd, errValid, hostTxValid, hostRxValid;
  logic        hostCtl, hostEnd, auxInValid, auxValid, auxReady, se;
  logic        hostOutValid, hostOutEnd, readEnable, resultGo, paramLoad;
  logic        hostDiag;
  logic [18:0] ioPins;
  logic [3:0]  scanCount;
  logic [1:0]  statKind;
  logic [7:0]  expq[$];
  logic [8:0]  hostq[$];
  int          err_total, cmp_count, goCnt, g0;
  int          cyc = 0, encN = 0, plCnt = 0;
  logic [15:0] ts;
  logic [18:0] iov;
  string       hdr;
  aux_diag_port #(.MS_CYC(10), .TEST_CYC(20)) dut (.*);
  aux_term_model term (.*);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Reading pulses and host-bound bytes as the design shows them
  always @(posedge ref_clk) begin
    if (resultGo === 1'b1) goCnt++;
    if (paramLoad === 1'b1) plCnt++;
    if (resetn === 1'b1) cyc <= cyc + 1;
    if (hostOutValid === 1'b1) hostq.push_back({hostOutEnd, hostOutData});
  end
  task complete_run;
    if (err_total == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task tmo;
    err_total++;
    complete_run;
  endtask
  task cmpw(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk) penable <= 1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo;
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task evt(input int s, input logic [7:0] b, input logic e, input logic [1:0] c);
    @(posedge ref_clk);
    case (s)
      0: {codeValid, codeData, codeEnd} <= {1'b1, b, e};
      1: {statValid, statData, statEnd, statKind} <= {1'b1, b, e, c};
      2: {errValid, errData} <= {1'b1, b};
      3, 4: {hostTxValid, hostRxValid, hostByte, hostCtl, hostEnd} <= {s == 3, s == 4, b, c[0], e};
      default: {auxInValid, auxInData} <= {1'b1, b};
    endcase
    @(posedge ref_clk);
    {codeValid, statValid, errValid, hostTxValid, hostRxValid, auxInValid} <= 6'h0;
    repeat (2) @(posedge ref_clk);
  endtask
  task expl(input string s);
    foreach (s[i]) expq.push_back(s[i]);
    expq.push_back(8'h0d);
    expq.push_back(8'h0a);
  endtask
  task chkaux;
    int n;
    n = 0;
    while (term.rxq.size() < expq.size() && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) tmo;
    repeat (20) @(posedge ref_clk);
    cmpw(term.rxq.size(), expq.size());
    foreach (expq[i]) if (i < term.rxq.size()) cmpw(term.rxq[i], expq[i]);
    term.rxq.delete();
    expq.delete();
  endtask
  task waitre;
    int n;
    n = 0;
    while (readEnable !== 1'b1 && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 500) tmo;
  endtask
  task enc(input int n);
    repeat (n) begin
      encN++;
      @(posedge ref_clk) encPin <= 1;
      repeat (3) @(posedge ref_clk);
      encPin <= 0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  // Main sequence
  initial begin
    {psel, penable, pwrite, trigPin, encPin, hwFault, scanErr, resetn} = 8'h0;
    {paddr, pwdata, ioPins, scanCount, statKind} = {8'h0, 32'h0, 19'h0, 4'h1, 2'h0};
    {codeValid, codeEnd, statValid, statEnd, errValid, hostCtl, hostEnd} = 7'h0;
    {codeData, statData, errData, hostByte, auxInData} = 40'h0;
    {hostTxValid, hostRxValid, auxInValid} = 3'h0;
    {err_total, cmp_count, goCnt} = 0;
    void'($urandom(32'h96bd7dbf));
    repeat (4) @(posedge ref_clk);
    resetn <= 1;
    apb(0, `A_MODE, 0);
    cmpw(rd, `M_DIAG);
    apb(0, `A_CTRL, 0);
    cmpw(rd, 32'h0);
    apb(0, `A_FIELD, 0);
    cmpw(rd, `FIELD_RST);
    apb(0, 8'h1c, 0);
    cmpw({se, rd[30:0]}, 32'h80000000);
    cmpw(readEnable, 0);
    waitre;
    expl("15000");
    chkaux;
    apb(0, `A_STATUS, 0);
    cmpw({rd[31:16], rd[1:0]}, {16'd15000, 2'h1});
    apb(1, `A_MODE, 9);
    apb(0, `A_MODE, 0);
    cmpw(rd, `M_DIAG);
    x = $urandom_range(8'h5a, 8'h41);
    evt(0, x, 0, 0);
    evt(0, x ^ 8'h20, 1, 0);
    expq = '{x, x ^ 8'h20, 8'h0a};
    chkaux;
    apb(1, `A_MODE, `M_MON);
    evt(3, x, 0, 0);
    evt(3, 8'h15, 0, 1);
    evt(3, 8'h03, 1, 1);
    evt(4, x + 8'h1, 0, 0);
    evt(4, 8'h03, 1, 1);
    expl($sformatf("O%c", x));
    expl($sformatf("I%c", x + 8'h1));
    chkaux;
    for (int m = 3; m < 6; m++) begin
      apb(1, `A_MODE, m);
      evt(1, 8'h40 + m, 1, m - 3);
      evt(1, 8'h60, 1, m - 2);
      expq.push_back(8'h40 + m);
      chkaux;
    end
    for (int m = 6; m < 8; m++) begin
      apb(1, `A_MODE, m);
      evt(1, 8'h53, 1, (m - 6) * 2);
      evt(2, 8'h45 + m, 0, 0);
      expq.push_back(8'h45 + m);
      chkaux;
    end
    apb(1, `A_MODE, `M_MAN);
    evt(5, x, 0, 0);
    evt(5, 8'h0d, 0, 0);
    cmpw(hostq.size(), 2);
    cmpw({hostq[0], hostq[1]}, {1'b0, x, 9'h10d});
    apb(1, `A_MODE, `M_DIAG);
    apb(1, `A_FIELD, 3);
    g0 = goCnt;
    trigPin <= 1;
    repeat (5) @(posedge ref_clk);
    trigPin <= 0;
    repeat (40) @(posedge ref_clk);
    cmpw(goCnt, g0);
    enc(3);
    repeat (10) @(posedge ref_clk);
    cmpw(goCnt, g0 + 1);
    apb(1, `A_CTRL, 4);
    repeat (5) @(posedge ref_clk);
    apb(1, `A_CTRL, 0);
    repeat (20) @(posedge ref_clk);
    cmpw(goCnt, g0 + 1);
    enc(3);
    repeat (10) @(posedge ref_clk);
    cmpw(goCnt, g0 + 2);
    apb(1, `A_CTRL, 32'h12);
    repeat (3) @(posedge ref_clk);
    cmpw({readEnable, hostDiag}, 2'b01);
    apb(0, `A_PULSES, 0);
    cmpw(rd, goCnt);
    apb(1, `A_PULSES, 0);
    apb(0, `A_PULSES, 0);
    cmpw(rd, 0);
    apb(1, `A_CTRL, 0);
    waitre;
    cmpw(readEnable, 1);
    for (int k = 1; k < 4; k++) begin
      {hwFault, scanCount, scanErr} <= {k == 1, (k == 2) ? 4'h2 : 4'h1, k == 3};
      apb(1, `A_CTRL, 1);
      repeat (3) @(posedge ref_clk);
      cmpw(readEnable, 0);
      expl($sformatf("%0d", 15000 + k));
      chkaux;
      cmpw(readEnable, 0);
      apb(1, `A_CTRL, 8);
      waitre;
      cmpw(readEnable, 1);
    end
    // I/O monitor: one stamped status line for one change to a random pin pattern
    apb(1, `A_MODE, `M_IOMON);
    iov = $urandom_range(19'h7ffff, 1);
    ioPins <= iov;
    ts = (cyc + 3) / 10;
    hdr = $sformatf("%h %h ", ts, encN[15:0]);
    hdr = hdr.toupper();
    foreach (hdr[i]) expq.push_back(hdr[i]);
    for (int i = 0; i < 19; i++) expq.push_back(iov[i] ? 8'h31 : 8'h2e);
    expl("");
    chkaux;
    cmpw(plCnt, 1);
    complete_run;
  end
endmodule // aux_diag_port_tb_top
